// >>> logic/crx_top.sv
// Receive diagnostic counters and pipeline Z filter with AHB-Lite registers
// Contract
// R1 - 8-bit read-only count of packets received by the first physical layer
// R2 - 8-bit read-only count of packets processed by the first controller
// R3 - 8-bit read-only count of packets handled by the tunnel path
// R4 - 8-bit read-only count of incoming clock lane rising edges
// R5 - Counters reset to zero and wrap past maximum
// R6 - Selector bits 7:6 match VC low bits, bits 5:0 match datatype
// R7 - Only two VC bits compared, so VC n and n+4k alias
// R8 - With all selector enables clear, every packet goes to pipeline Z
// R9 - With any enable set, only matching packets go to pipeline Z
`timescale 1ns/1ns
module crx_top import crx_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Receive front end, same clock
   input wire logic phy_pkt_stb,
   input wire logic ctrl_pkt_stb,
   input wire logic tun_pkt_stb,
   input wire logic pkt_valid,
   input wire logic [3:0] pkt_vc,
   input wire logic [5:0] pkt_dt,
   // Clock lane pin
   input wire logic csi_clk_lane,
   // Pipeline Z stream
   output logic pipe_z_valid,
   output logic [3:0] pipe_z_vc,
   output logic [5:0] pipe_z_dt
);
   logic [7:0] phy_cnt, ctrl_cnt, tun_cnt, clk_cnt;
   logic clk_edge;

   crx_wrap_cnt u_phy_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .inc(phy_pkt_stb), // [R1]
      .cnt_r(phy_cnt)
   );

   crx_wrap_cnt u_ctrl_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .inc(ctrl_pkt_stb), // [R2]
      .cnt_r(ctrl_cnt)
   );

   crx_wrap_cnt u_tun_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .inc(tun_pkt_stb), // [R3]
      .cnt_r(tun_cnt)
   );

   crx_sync_edge u_clk_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(csi_clk_lane),
      .rise_r(clk_edge)
   );

   crx_wrap_cnt u_clk_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .inc(clk_edge), // [R4]
      .cnt_r(clk_cnt)
   );

   // Writable selector state
   logic [7:0] sel_a_r, sel_b_r, sel_c_r, sel_d_r;
   logic [7:0] sel_a_nxt, sel_b_nxt, sel_c_nxt, sel_d_nxt;
   logic [3:0] sel_en_r, sel_en_nxt;

   // AHB-Lite slave state
   logic wr_pend_r, wr_pend_nxt;
   logic [11:0] wr_idx_r, wr_idx_nxt;
   logic [31:0] hrdata_nxt;
   logic addr_ok;
   logic [11:0] a_idx;

   function automatic logic [7:0] rd_mux(input logic [11:0] idx, input logic [7:0] c0,
                                         input logic [7:0] c1, input logic [7:0] c2,
                                         input logic [7:0] c3, input logic [7:0] s0,
                                         input logic [7:0] s1, input logic [7:0] s2,
                                         input logic [7:0] s3, input logic [3:0] en);
      rd_mux = 8'h00;
      unique case (idx)
         CRX_IDX_PHY_CNT: rd_mux = c0;
         CRX_IDX_CTRL_CNT: rd_mux = c1;
         CRX_IDX_TUN_CNT: rd_mux = c2;
         CRX_IDX_CLK_CNT: rd_mux = c3;
         CRX_IDX_SEL_A: rd_mux = s0;
         CRX_IDX_SEL_B: rd_mux = s1;
         CRX_IDX_SEL_C: rd_mux = s2;
         CRX_IDX_SEL_D: rd_mux = s3;
         CRX_IDX_SEL_EN: rd_mux = {4'h0, en};
         default: rd_mux = 8'h00;
      endcase
   endfunction

   always_comb begin
      a_idx = haddr[13:2];
      addr_ok = hsel && hready && (htrans == CRX_HTRANS_NONSEQ) &&
                (hsize == CRX_HSIZE_WORD);
      wr_pend_nxt = addr_ok && hwrite;
      wr_idx_nxt = addr_ok ? a_idx : wr_idx_r;
      hrdata_nxt = 32'h0000_0000;
      if (addr_ok && !hwrite) begin
         hrdata_nxt = {24'h00_0000, rd_mux(a_idx, phy_cnt, ctrl_cnt, tun_cnt, clk_cnt,
                                          sel_a_r, sel_b_r, sel_c_r, sel_d_r,
                                          sel_en_r)};
      end
   end

   // Counters have no write path, so writes to them are dropped
   always_comb begin
      sel_a_nxt = sel_a_r;
      sel_b_nxt = sel_b_r;
      sel_c_nxt = sel_c_r;
      sel_d_nxt = sel_d_r;
      sel_en_nxt = sel_en_r;
      if (wr_pend_r) begin
         unique case (wr_idx_r)
            CRX_IDX_SEL_A: sel_a_nxt = hwdata[7:0];
            CRX_IDX_SEL_B: sel_b_nxt = hwdata[7:0];
            CRX_IDX_SEL_C: sel_c_nxt = hwdata[7:0];
            CRX_IDX_SEL_D: sel_d_nxt = hwdata[7:0];
            CRX_IDX_SEL_EN: sel_en_nxt = hwdata[3:0];
            default: sel_a_nxt = sel_a_r;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 12'h000;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         sel_a_r <= CRX_SEL_RST;
         sel_b_r <= CRX_SEL_RST;
         sel_c_r <= CRX_SEL_RST;
         sel_d_r <= CRX_SEL_RST;
         sel_en_r <= CRX_EN_RST;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         wr_idx_r <= wr_idx_nxt;
         hrdata <= hrdata_nxt;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         sel_a_r <= sel_a_nxt;
         sel_b_r <= sel_b_nxt;
         sel_c_r <= sel_c_nxt;
         sel_d_r <= sel_d_nxt;
         sel_en_r <= sel_en_nxt;
      end
   end

   // Pipeline Z filter
   logic [CRX_NSEL-1:0] hit;
   logic route;
   logic pz_valid_nxt;
   logic [3:0] pz_vc_nxt;
   logic [5:0] pz_dt_nxt;

   always_comb begin
      hit[0] = crx_sel_hit(sel_a_r, pkt_vc, pkt_dt); // [R6] [R7]
      hit[1] = crx_sel_hit(sel_b_r, pkt_vc, pkt_dt); // [R6] [R7]
      hit[2] = crx_sel_hit(sel_c_r, pkt_vc, pkt_dt); // [R6] [R7]
      hit[3] = crx_sel_hit(sel_d_r, pkt_vc, pkt_dt); // [R6] [R7]
      route = (sel_en_r == CRX_EN_RST) || |(hit & sel_en_r); // [R8] [R9]
      pz_valid_nxt = pkt_valid && route;
      pz_vc_nxt = pkt_valid ? pkt_vc : pipe_z_vc;
      pz_dt_nxt = pkt_valid ? pkt_dt : pipe_z_dt;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pipe_z_valid <= 1'b0;
         pipe_z_vc <= 4'h0;
         pipe_z_dt <= 6'h00;
      end else begin
         pipe_z_valid <= pz_valid_nxt;
         pipe_z_vc <= pz_vc_nxt;
         pipe_z_dt <= pz_dt_nxt;
      end
   end

   // Checks
   property p_phy_cnt;
      @(posedge clk) disable iff (sys_rst)
         phy_pkt_stb |=> phy_cnt == 8'($past(phy_cnt) + CRX_CNT_ONE);
   endproperty
   a_phy_cnt: assert property (p_phy_cnt) else $error("phy count missed a packet"); // [R1]

   property p_ctrl_cnt;
      @(posedge clk) disable iff (sys_rst)
         ctrl_pkt_stb |=> ctrl_cnt == 8'($past(ctrl_cnt) + CRX_CNT_ONE);
   endproperty
   a_ctrl_cnt: assert property (p_ctrl_cnt) else $error("controller count wrong"); // [R2]

   property p_tun_cnt;
      @(posedge clk) disable iff (sys_rst)
         tun_pkt_stb |=> tun_cnt == 8'($past(tun_cnt) + CRX_CNT_ONE);
   endproperty
   a_tun_cnt: assert property (p_tun_cnt) else $error("tunnel count wrong"); // [R3]

   property p_clk_cnt;
      @(posedge clk) disable iff (sys_rst)
         $rose(u_clk_sync.s2_r) |=> ##1 clk_cnt == 8'($past(clk_cnt) + CRX_CNT_ONE);
   endproperty
   a_clk_cnt: assert property (p_clk_cnt) else $error("clock lane edge not counted"); // [R4]

   property p_rd_cnt;
      @(posedge clk) disable iff (sys_rst)
         (addr_ok && !hwrite && a_idx == CRX_IDX_PHY_CNT && !phy_pkt_stb)
         |=> hrdata == {24'h00_0000, phy_cnt};
   endproperty
   a_rd_cnt: assert property (p_rd_cnt) else $error("counter read mismatch"); // [R1]

   property p_alias;
      @(posedge clk) disable iff (sys_rst)
         (pkt_valid && sel_en_r == 4'h1 && sel_a_r[5:0] == pkt_dt &&
          sel_a_r[7:6] == pkt_vc[1:0]) |=> pipe_z_valid;
   endproperty
   a_alias: assert property (p_alias) else $error("aliased channel not routed"); // [R6] [R7]

   property p_no_filter;
      @(posedge clk) disable iff (sys_rst)
         (pkt_valid && sel_en_r == 4'h0) |=> (pipe_z_valid && pipe_z_dt == $past(pkt_dt));
   endproperty
   a_no_filter: assert property (p_no_filter) else $error("unfiltered packet dropped"); // [R8]

   property p_filter;
      @(posedge clk) disable iff (sys_rst)
         (pkt_valid && sel_en_r != 4'h0 && (hit & sel_en_r) == 4'h0) |=> !pipe_z_valid;
   endproperty
   a_filter: assert property (p_filter) else $error("unmatched packet routed"); // [R9]

   property p_vc_mismatch;
      @(posedge clk) disable iff (sys_rst)
         (pkt_valid && sel_en_r == 4'h1 && sel_a_r[7:6] != pkt_vc[1:0]) |=> !pipe_z_valid;
   endproperty
   a_vc_mismatch: assert property (p_vc_mismatch) else $error("wrong channel routed"); // [R6]

   property p_cnt_reset;
      @(posedge clk) $fell(sys_rst) |-> (phy_cnt == CRX_CNT_RST && ctrl_cnt == CRX_CNT_RST &&
         tun_cnt == CRX_CNT_RST && clk_cnt == CRX_CNT_RST);
   endproperty
   a_cnt_reset: assert property (p_cnt_reset) else $error("counter not zero after reset"); // [R5]

   property p_cnt_ro;
      @(posedge clk) disable iff (sys_rst)
         (wr_pend_r && wr_idx_r == CRX_IDX_PHY_CNT && !phy_pkt_stb) |=> $stable(phy_cnt);
   endproperty
   a_cnt_ro: assert property (p_cnt_ro) else $error("counter took a bus write"); // [R1]

   property p_sel_wr;
      @(posedge clk) disable iff (sys_rst)
         (wr_pend_r && wr_idx_r == CRX_IDX_SEL_A)
         |=> {24'h00_0000, sel_a_r} == ($past(hwdata) & 32'h0000_00ff);
   endproperty
   a_sel_wr: assert property (p_sel_wr) else $error("selector write lost"); // [R6]

   property p_en_wr;
      @(posedge clk) disable iff (sys_rst)
         (wr_pend_r && wr_idx_r == CRX_IDX_SEL_EN)
         |=> {28'h000_0000, sel_en_r} == ($past(hwdata) & 32'h0000_000f);
   endproperty
   a_en_wr: assert property (p_en_wr) else $error("enable write lost"); // [R8]

   property p_sel_b_route;
      @(posedge clk) disable iff (sys_rst)
         (pkt_valid && sel_en_r[1] && sel_b_r == {pkt_vc[1:0], pkt_dt}) |=> pipe_z_valid;
   endproperty
   a_sel_b_route: assert property (p_sel_b_route) else $error("selector b match dropped"); // [R9]

   property p_sel_c_route;
      @(posedge clk) disable iff (sys_rst)
         (pkt_valid && sel_en_r[2] && sel_c_r == {pkt_vc[1:0], pkt_dt}) |=> pipe_z_valid;
   endproperty
   a_sel_c_route: assert property (p_sel_c_route) else $error("selector c match dropped"); // [R7]

   property p_sel_d_route;
      @(posedge clk) disable iff (sys_rst)
         (pkt_valid && sel_en_r[3] && sel_d_r == {pkt_vc[1:0], pkt_dt}) |=> pipe_z_valid;
   endproperty
   a_sel_d_route: assert property (p_sel_d_route) else $error("selector d match dropped"); // [R9]

   property p_no_packet;
      @(posedge clk) disable iff (sys_rst) !pkt_valid |=> !pipe_z_valid;
   endproperty
   a_no_packet: assert property (p_no_packet) else $error("route without a packet"); // [R9]
endmodule

// >>> logic/crx_pkg.sv
// Constants, register map and selector matching for the receive counters block
package crx_pkg;
   localparam int CRX_AW = 12;
   // Register indexes; byte address is four times the index
   localparam logic [11:0] CRX_IDX_PHY_CNT = 12'h038d;
   localparam logic [11:0] CRX_IDX_CTRL_CNT = 12'h038e;
   localparam logic [11:0] CRX_IDX_TUN_CNT = 12'h038f;
   localparam logic [11:0] CRX_IDX_CLK_CNT = 12'h0390;
   localparam logic [11:0] CRX_IDX_SEL_A = 12'h03c8;
   localparam logic [11:0] CRX_IDX_SEL_B = 12'h03c9;
   localparam logic [11:0] CRX_IDX_SEL_C = 12'h03ca;
   localparam logic [11:0] CRX_IDX_SEL_D = 12'h03cb;
   localparam logic [11:0] CRX_IDX_SEL_EN = 12'h03d1;
   // Reset values
   localparam logic [7:0] CRX_CNT_RST = 8'h00;
   localparam logic [7:0] CRX_SEL_RST = 8'h00;
   localparam logic [3:0] CRX_EN_RST = 4'h0;
   localparam logic [7:0] CRX_CNT_ONE = 8'h01;
   // Selector fields
   localparam int CRX_SEL_VC_HI = 7;
   localparam int CRX_SEL_VC_LO = 6;
   localparam int CRX_SEL_DT_HI = 5;
   localparam int CRX_SEL_DT_LO = 0;
   localparam int CRX_NSEL = 4;
   // AHB encodings
   localparam logic [1:0] CRX_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] CRX_HSIZE_WORD = 3'h2;

   // Selector hit: low two VC bits and the six datatype bits
   function automatic logic crx_sel_hit(input logic [7:0] sel, input logic [3:0] vc,
                                        input logic [5:0] dt);
      crx_sel_hit = (sel[CRX_SEL_VC_HI:CRX_SEL_VC_LO] == vc[1:0]) &&
                    (sel[CRX_SEL_DT_HI:CRX_SEL_DT_LO] == dt);
   endfunction
endpackage

// >>> logic/crx_sync_edge.sv
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ns
module crx_sync_edge import crx_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic async_in,
   output logic rise_r
);
   logic s1_r, s2_r, s3_r;
   logic s1_nxt, s2_nxt, s3_nxt, rise_nxt;

   always_comb begin
      s1_nxt = async_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      rise_nxt = s2_r & ~s3_r;
   end

   // Sync chain tracks the pin through reset, so a lane parked high gives no false edge
   always_ff @(posedge clk) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      if (sys_rst) begin
         rise_r <= 1'b0;
      end else begin
         rise_r <= rise_nxt;
      end
   end

   property p_rise_one;
      @(posedge clk) disable iff (sys_rst) rise_r |=> !rise_r;
   endproperty
   a_rise_one: assert property (p_rise_one) else $error("edge pulse longer than one cycle"); // [R4]
endmodule

// >>> logic/crx_wrap_cnt.sv
// Eight-bit wrapping event counter
`timescale 1ns/1ns
module crx_wrap_cnt import crx_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic inc,
   output logic [7:0] cnt_r
);
   logic [7:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (inc) begin
         cnt_nxt = 8'(cnt_r + CRX_CNT_ONE); // [R5]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= CRX_CNT_RST; // [R5]
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   property p_cnt_wrap;
      @(posedge clk) disable iff (sys_rst) (inc && cnt_r == 8'hff) |=> cnt_r == 8'h00;
   endproperty
   a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap to zero"); // [R5]

   property p_cnt_hold;
      @(posedge clk) disable iff (sys_rst) !inc |=> $stable(cnt_r);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without event"); // [R5]
endmodule

// >>> dv/crx_sensor_model.sv
// Behavioural model of the image sensor transmitter feeding the receive block
`timescale 1ns/1ns
module crx_sensor_model (
   input wire logic clk,
   input wire logic lane_on,
   output logic phy_pkt_stb,
   output logic ctrl_pkt_stb,
   output logic tun_pkt_stb,
   output logic pkt_valid,
   output logic [3:0] pkt_vc,
   output logic [5:0] pkt_dt,
   output logic csi_clk_lane
);
   int rises;

   initial begin
      {phy_pkt_stb, ctrl_pkt_stb, tun_pkt_stb, pkt_valid} = 4'h0;
      pkt_vc = 4'h0;
      pkt_dt = 6'h00;
      csi_clk_lane = 1'b0;
      rises = 0;
      // Lane phase kept off the system clock edges; stands still when off
      #3;
      forever begin
         #40;
         if (lane_on) begin
            csi_clk_lane = ~csi_clk_lane;
            rises += csi_clk_lane;
         end
      end
   end

   // One packet header with its strobes for one cycle
   task automatic send(input logic [3:0] vc, input logic [5:0] dt, input logic [2:0] stb);
      @(posedge clk);
      pkt_valid <= 1'b1;
      pkt_vc <= vc;
      pkt_dt <= dt;
      {phy_pkt_stb, ctrl_pkt_stb, tun_pkt_stb} <= stb;
      @(posedge clk);
      pkt_valid <= 1'b0;
      {phy_pkt_stb, ctrl_pkt_stb, tun_pkt_stb} <= 3'h0;
      // Released header shows no stale value
      pkt_vc <= ~vc;
      pkt_dt <= ~dt;
   endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking testbench for the receive counters and pipeline Z filter
`timescale 1ns/1ns
module tb_top import crx_pkg::*; ;
   logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, lane_on;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic phy_pkt_stb, ctrl_pkt_stb, tun_pkt_stb, pkt_valid, csi_clk_lane, pipe_z_valid;
   logic [3:0] pkt_vc, pipe_z_vc;
   logic [5:0] pkt_dt, pipe_z_dt;
   int errors, samples_checked;
   logic [11:0] regs [9] = '{CRX_IDX_PHY_CNT, CRX_IDX_CTRL_CNT, CRX_IDX_TUN_CNT,
      CRX_IDX_CLK_CNT, CRX_IDX_SEL_A, CRX_IDX_SEL_B, CRX_IDX_SEL_C, CRX_IDX_SEL_D,
      CRX_IDX_SEL_EN};
   logic [11:0] sel [4] = '{CRX_IDX_SEL_A, CRX_IDX_SEL_B, CRX_IDX_SEL_C, CRX_IDX_SEL_D};

   assign hready = hreadyout;

   crx_top dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hrdata, .hresp, .phy_pkt_stb, .ctrl_pkt_stb, .tun_pkt_stb, .pkt_valid,
      .pkt_vc, .pkt_dt, .csi_clk_lane, .pipe_z_valid, .pipe_z_vc, .pipe_z_dt);

   crx_sensor_model sensor (.clk, .lane_on, .phy_pkt_stb, .ctrl_pkt_stb, .tun_pkt_stb,
      .pkt_valid, .pkt_vc, .pkt_dt, .csi_clk_lane);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_rdy;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         if (hready === 1'b1) return;
      end
      errors++;
      close_out();
   endtask

   task automatic xfer(input logic w, input logic [11:0] idx, input logic [7:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {18'h0_0000, idx, 2'h0};
      htrans <= CRX_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= CRX_HSIZE_WORD;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic rd_chk(input string what, input logic [11:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(what, {24'h00_0000, exp}, rd);
   endtask

   task automatic pz(input logic [3:0] vc, input logic [5:0] dt, input logic pass);
      sensor.send(vc, dt, 3'h0);
      #1;
      chk("pipe_z_valid", 32'(pass), 32'(pipe_z_valid));
      if (pass) chk("pipe_z_header", {22'h0, vc, dt}, {22'h0, pipe_z_vc, pipe_z_dt});
   endtask

   initial begin
      sys_rst = 1'b1;
      {hsel, hwrite, lane_on} = 3'h0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'h0;
      hsize = CRX_HSIZE_WORD;
      errors = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (regs[i]) rd_chk("reset_value", regs[i], 8'h00);
      rd_chk("unmapped", 12'h0391, 8'h00);
      foreach (sel[i]) xfer(1'b1, sel[i], 8'h5A ^ 8'(i));
      foreach (sel[i]) rd_chk("selector", sel[i], 8'h5A ^ 8'(i));
      $display("Test registers done");
      for (int i = 0; i < 259; i++) sensor.send(4'h0, 6'h00, {1'b1, i < 5, i < 2});
      rd_chk("phy_count", CRX_IDX_PHY_CNT, 8'h03);
      rd_chk("ctrl_count", CRX_IDX_CTRL_CNT, 8'h05);
      rd_chk("tunnel_count", CRX_IDX_TUN_CNT, 8'h02);
      xfer(1'b1, CRX_IDX_PHY_CNT, 8'hAA);
      rd_chk("phy_read_only", CRX_IDX_PHY_CNT, 8'h03);
      lane_on <= 1'b1;
      for (int n = 0; n < 200 && sensor.rises < 10; n++) @(posedge clk);
      if (sensor.rises < 10) begin
         errors++;
         close_out();
      end
      lane_on <= 1'b0;
      repeat (8) @(posedge clk);
      rd_chk("lane_count", CRX_IDX_CLK_CNT, 8'h0A);
      $display("Test counters done");
      pz(4'h5, 6'h2B, 1'b1);
      xfer(1'b1, CRX_IDX_SEL_A, 8'h6B);
      xfer(1'b1, CRX_IDX_SEL_C, 8'hD2);
      xfer(1'b1, CRX_IDX_SEL_EN, 8'h01);
      for (int k = 0; k < 4; k++) pz(4'(1 + 4 * k), 6'h2B, 1'b1);
      pz(4'h2, 6'h2B, 1'b0);
      pz(4'h1, 6'h2A, 1'b0);
      pz(4'h3, 6'h12, 1'b0);
      xfer(1'b1, CRX_IDX_SEL_EN, 8'h05);
      pz(4'hF, 6'h12, 1'b1);
      pz(4'h3, 6'h12, 1'b1);
      pz(4'h0, 6'h12, 1'b0);
      xfer(1'b1, CRX_IDX_SEL_EN, 8'h0A);
      pz(4'h9, 6'h19, 1'b1);
      pz(4'hD, 6'h1B, 1'b1);
      pz(4'h1, 6'h2B, 1'b0);
      xfer(1'b1, CRX_IDX_SEL_EN, 8'h00);
      pz(4'h0, 6'h12, 1'b1);
      chk("hresp", 32'h0000_0000, 32'(hresp));
      $display("Test filter done");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (regs[i]) rd_chk("after_reset", regs[i], 8'h00);
      $display("Test reset done");
      close_out();
   end
endmodule
